// ---- rtl/clock_select_and_module_stop.sv ----
// Clock ratio selection and module stop control with an APB register slave
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module clock_select_and_module_stop (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_request,
  input wire logic bus_io_halted,
  input wire logic wake_request,
  output logic system_clk_en,
  output logic peripheral_clk_en,
  output logic bus_clk_en,
  output logic dma_module_stop,
  output logic [clock_select_pkg::TIMER_CHANNELS-1:0] timer_channel_stop,
  output logic all_clock_stopped
);

  clock_select_pkg::ratio_ctrl_t ratio;
  clock_select_pkg::module_stop_t stop_ctrl;
  clock_select_pkg::stop_state_t stop_state;
  logic access;
  logic wr_en;
  logic sel_ratio;
  logic sel_stop;
  logic sel_status;
  logic mapped;
  logic system_tick;
  logic peripheral_tick;
  logic bus_tick;
  logic [15:0] ratio_word;
  logic [15:0] stop_word;
  logic [15:0] status_word;
  logic [31:0] next_prdata;

  // Access phase completes on the cycle where pready is high
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite;

  // Address decode
  always_comb begin
    sel_ratio = 1'b0;
    sel_stop = 1'b0;
    sel_status = 1'b0;
    if (paddr == clock_select_pkg::CLOCK_RATIO_CONTROL_ADDR) begin
      sel_ratio = 1'b1;
    end else if (paddr == clock_select_pkg::MODULE_STOP_CONTROL_A_ADDR) begin
      sel_stop = 1'b1;
    end else if (paddr == clock_select_pkg::CLOCK_STATUS_ADDR) begin
      sel_status = 1'b1;
    end
  end

  assign mapped = sel_ratio | sel_stop | sel_status;

  // Ratio register image; unused bits read zero
  always_comb begin
    ratio_word = 16'h0000;
    ratio_word[clock_select_pkg::SYSTEM_RATIO_LSB +: 3] = ratio.system_ratio;
    ratio_word[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3] = ratio.peripheral_ratio;
    ratio_word[clock_select_pkg::BUS_RATIO_LSB +: 3] = ratio.bus_ratio;
  end

  // Module stop register image; only three bits exist
  always_comb begin
    stop_word = 16'h0000;
    stop_word[clock_select_pkg::ALL_CLOCK_STOP_ENABLE_BIT] = stop_ctrl.all_clock_stop_enable;
    stop_word[clock_select_pkg::DMA_MODULE_STOP_BIT] = stop_ctrl.dma_module_stop;
    stop_word[clock_select_pkg::TIMER_MODULE_STOP_BIT] = stop_ctrl.timer_module_stop;
  end

  // Status register image, read only
  always_comb begin
    status_word = 16'h0000;
    status_word[clock_select_pkg::STATUS_STOPPED_BIT] = (stop_state == clock_select_pkg::STOP_STOPPED);
    status_word[clock_select_pkg::STATUS_WAIT_HALT_BIT] = (stop_state == clock_select_pkg::STOP_WAIT_HALT);
  end

  // Read data mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (sel_ratio) begin
      next_prdata = {16'h0000, ratio_word};
    end else if (sel_stop) begin
      next_prdata = {16'h0000, stop_word};
    end else if (sel_status) begin
      next_prdata = {16'h0000, status_word};
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Error answer for an address that maps to no register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  // Read data stands only with pready; a write answers with zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= 32'h0000_0000;
    end
  end

  // Ratio fields; a reserved code leaves its field unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio.system_ratio <= clock_select_pkg::SYSTEM_RATIO_RESET;
      ratio.peripheral_ratio <= clock_select_pkg::PERIPHERAL_RATIO_RESET;
      ratio.bus_ratio <= clock_select_pkg::BUS_RATIO_RESET;
    end else if (wr_en && sel_ratio) begin
      if (pstrb[1] && pwdata[clock_select_pkg::SYSTEM_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X4) begin
        ratio.system_ratio <= pwdata[clock_select_pkg::SYSTEM_RATIO_LSB +: 3];
      end
      if (pstrb[0] && (pwdata[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X4
          || pwdata[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X2)) begin
        ratio.peripheral_ratio <= pwdata[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3];
      end
      if (pstrb[0] && (pwdata[clock_select_pkg::BUS_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X4
          || pwdata[clock_select_pkg::BUS_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X2)) begin
        ratio.bus_ratio <= pwdata[clock_select_pkg::BUS_RATIO_LSB +: 3];
      end
    end
  end

  // Module stop bits, high byte and low byte written by their lanes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ctrl.all_clock_stop_enable <= clock_select_pkg::MODULE_STOP_RESET;
      stop_ctrl.dma_module_stop <= clock_select_pkg::MODULE_STOP_RESET;
      stop_ctrl.timer_module_stop <= clock_select_pkg::MODULE_STOP_RESET;
    end else if (wr_en && sel_stop) begin
      if (pstrb[1]) begin
        stop_ctrl.all_clock_stop_enable <= pwdata[clock_select_pkg::ALL_CLOCK_STOP_ENABLE_BIT];
        stop_ctrl.dma_module_stop <= pwdata[clock_select_pkg::DMA_MODULE_STOP_BIT];
      end
      if (pstrb[0]) begin
        stop_ctrl.timer_module_stop <= pwdata[clock_select_pkg::TIMER_MODULE_STOP_BIT];
      end
    end
  end

  // Per-domain enable generators
  ratio_divider u_system_div (
    .pclk(pclk),
    .presetn(presetn),
    .ratio_code(ratio.system_ratio),
    .tick(system_tick)
  );

  ratio_divider u_peripheral_div (
    .pclk(pclk),
    .presetn(presetn),
    .ratio_code(ratio.peripheral_ratio),
    .tick(peripheral_tick)
  );

  ratio_divider u_bus_div (
    .pclk(pclk),
    .presetn(presetn),
    .ratio_code(ratio.bus_ratio),
    .tick(bus_tick)
  );

  // All-module clock stop sequencer
  module_stop_ctrl u_stop (
    .pclk(pclk),
    .presetn(presetn),
    .stop_ctrl(stop_ctrl),
    .sleep_request(sleep_request),
    .bus_io_halted(bus_io_halted),
    .wake_request(wake_request),
    .state(stop_state),
    .all_clock_stopped(all_clock_stopped)
  );

  // System enable, held low while every module clock is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clk_en <= 1'b0;
    end else begin
      system_clk_en <= system_tick & ~all_clock_stopped;
    end
  end

  // Peripheral enable, held low while every module clock is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_clk_en <= 1'b0;
    end else begin
      peripheral_clk_en <= peripheral_tick & ~all_clock_stopped;
    end
  end

  // Bus enable, held low while every module clock is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clk_en <= 1'b0;
    end else begin
      bus_clk_en <= bus_tick & ~all_clock_stopped;
    end
  end

  // Module stop outputs; one bit covers all timer channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_module_stop <= 1'b0;
    end else begin
      dma_module_stop <= stop_ctrl.dma_module_stop;
    end
  end

  for (genvar ch = 0; ch < clock_select_pkg::TIMER_CHANNELS; ch++) begin : g_timer_stop
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        timer_channel_stop[ch] <= 1'b0;
      end else begin
        timer_channel_stop[ch] <= stop_ctrl.timer_module_stop;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Enables follow the ratio; repeat counts cover the two-stage tick pipeline after reset
  system_x4_a: assert property (
    (ratio.system_ratio == clock_select_pkg::RATIO_X4 && !all_clock_stopped) [*4]
    |-> system_clk_en) else $error("system enable missing at x4");
  peripheral_x2_a: assert property (
    (ratio.peripheral_ratio == clock_select_pkg::RATIO_X2 && !all_clock_stopped) [*5]
    |-> peripheral_clk_en != $past(peripheral_clk_en)) else $error("peripheral enable not half rate");
  bus_x4_a: assert property (
    (ratio.bus_ratio == clock_select_pkg::RATIO_X4 && !all_clock_stopped) [*4]
    |-> bus_clk_en) else $error("bus enable missing at x4");
  stopped_gates_a: assert property (
    all_clock_stopped |=> !system_clk_en && !peripheral_clk_en && !bus_clk_en)
    else $error("enable active during clock stop");

  // Register fields change only by an addressed write with a legal code
  system_write_a: assert property (
    wr_en && sel_ratio && pstrb[1] && pwdata[clock_select_pkg::SYSTEM_RATIO_LSB +: 3] == clock_select_pkg::RATIO_X4
    |=> ratio.system_ratio == clock_select_pkg::RATIO_X4) else $error("system ratio write lost");
  reserved_hold_a: assert property (
    wr_en && sel_ratio && pwdata[clock_select_pkg::SYSTEM_RATIO_LSB +: 3] != clock_select_pkg::RATIO_X4
    |=> ratio.system_ratio == $past(ratio.system_ratio)) else $error("reserved code changed ratio");
  peripheral_hold_a: assert property (
    wr_en && sel_ratio && pwdata[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3] != clock_select_pkg::RATIO_X4
    && pwdata[clock_select_pkg::PERIPHERAL_RATIO_LSB +: 3] != clock_select_pkg::RATIO_X2
    |=> ratio.peripheral_ratio == $past(ratio.peripheral_ratio)) else $error("reserved code changed peripheral ratio");
  bus_hold_a: assert property (
    wr_en && sel_ratio && pwdata[clock_select_pkg::BUS_RATIO_LSB +: 3] != clock_select_pkg::RATIO_X4
    && pwdata[clock_select_pkg::BUS_RATIO_LSB +: 3] != clock_select_pkg::RATIO_X2
    |=> ratio.bus_ratio == $past(ratio.bus_ratio)) else $error("reserved code changed bus ratio");
  ratio_hold_a: assert property (
    !(wr_en && sel_ratio) |=> ratio == $past(ratio)) else $error("ratio changed without a write");
  stop_hold_a: assert property (
    !(wr_en && sel_stop) |=> stop_ctrl == $past(stop_ctrl)) else $error("stop bits changed without a write");
  all_clock_stop_enable_write_a: assert property (
    wr_en && sel_stop && pstrb[1]
    |=> stop_ctrl.all_clock_stop_enable == $past(pwdata[clock_select_pkg::ALL_CLOCK_STOP_ENABLE_BIT]))
    else $error("clock stop enable does not follow write");
  dma_stop_write_a: assert property (
    wr_en && sel_stop && pstrb[1]
    |=> ##1 dma_module_stop == $past(pwdata[clock_select_pkg::DMA_MODULE_STOP_BIT], 2))
    else $error("dma stop does not follow write");
  timer_stop_write_a: assert property (
    wr_en && sel_stop && pstrb[0]
    |=> ##1 timer_channel_stop
    == {clock_select_pkg::TIMER_CHANNELS{$past(pwdata[clock_select_pkg::TIMER_MODULE_STOP_BIT], 2)}})
    else $error("timer stop does not follow write");
  timer_group_a: assert property (
    timer_channel_stop == {clock_select_pkg::TIMER_CHANNELS{$past(stop_ctrl.timer_module_stop)}})
    else $error("timer channels not gated together");

  // APB answer: one wait state, error for an unmapped address, data only with pready
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready) else $error("access not one wait state");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  unmapped_error_a: assert property (psel && penable && !pready && !mapped |=> pready && pslverr)
    else $error("unmapped access without error");
  unmapped_ignored_a: assert property (wr_en && !mapped |=> ratio == $past(ratio) && stop_ctrl == $past(stop_ctrl))
    else $error("unmapped write changed a register");
  read_idle_zero_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside pready");
  write_data_zero_a: assert property (pready && pwrite |-> prdata == 32'h0000_0000) else $error("read data on a write");

  ratio_write_c: cover property (wr_en && sel_ratio);
  bad_addr_c: cover property (pready && pslverr);
  dma_stop_c: cover property ($rose(dma_module_stop));

endmodule : clock_select_and_module_stop
`default_nettype wire

// ---- rtl/clock_select_pkg.sv ----
// Constants, field layouts and carrier types for clock ratio selection and module stop
//
// Contract
// - System ratio bits 10:8, code 000 gives x4
// - Peripheral ratio bits 6:4, code 001 gives x2
// - Bus ratio bits 2:0, code 000 gives x4
// - Stop bit 1 stops module, 0 releases
// - Bit 15 enables all-module clock stop on sleep
// - Bit 14 gates DMA, bit 0 gates timers
package clock_select_pkg;

  // Register byte addresses on the APB
  localparam logic [23:0] CLOCK_RATIO_CONTROL_ADDR = 24'hfffdc4;
  localparam logic [23:0] MODULE_STOP_CONTROL_A_ADDR = 24'hfffdc8;
  localparam logic [23:0] CLOCK_STATUS_ADDR = 24'hfffdcc;

  // Field positions in the ratio register
  localparam int SYSTEM_RATIO_LSB = 8;
  localparam int PERIPHERAL_RATIO_LSB = 4;
  localparam int BUS_RATIO_LSB = 0;

  // Field positions in the module stop register
  localparam int ALL_CLOCK_STOP_ENABLE_BIT = 15;
  localparam int DMA_MODULE_STOP_BIT = 14;
  localparam int TIMER_MODULE_STOP_BIT = 0;

  // Field positions in the status register
  localparam int STATUS_STOPPED_BIT = 0;
  localparam int STATUS_WAIT_HALT_BIT = 1;

  // Ratio codes; all others are reserved
  localparam logic [2:0] RATIO_X4 = 3'h0;
  localparam logic [2:0] RATIO_X2 = 3'h1;

  // Reset values
  localparam logic [2:0] SYSTEM_RATIO_RESET = 3'h0;
  localparam logic [2:0] PERIPHERAL_RATIO_RESET = 3'h1;
  localparam logic [2:0] BUS_RATIO_RESET = 3'h0;
  localparam logic MODULE_STOP_RESET = 1'b0;

  // Number of timer channels gated by one stop bit
  localparam int TIMER_CHANNELS = 6;

  typedef struct packed {
    logic [2:0] system_ratio;
    logic [2:0] peripheral_ratio;
    logic [2:0] bus_ratio;
  } ratio_ctrl_t;

  typedef struct packed {
    logic all_clock_stop_enable;
    logic dma_module_stop;
    logic timer_module_stop;
  } module_stop_t;

  typedef enum logic [1:0] {
    STOP_IDLE,
    STOP_WAIT_HALT,
    STOP_STOPPED
  } stop_state_t;

endpackage : clock_select_pkg

// ---- rtl/ratio_divider.sv ----
// Clock enable generator for one clock domain from its ratio code
`timescale 1ns/1ps
`default_nettype none
module ratio_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] ratio_code,
  output logic tick
);

  logic phase;

  // Code x4 ticks every cycle, x2 ticks every second cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
      tick <= 1'b0;
    end else if (ratio_code == clock_select_pkg::RATIO_X4) begin
      phase <= 1'b0;
      tick <= 1'b1;
    end else begin
      phase <= ~phase;
      tick <= phase;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Four cycles at x2 so that the attempt on the reset-release edge sees a settled tick
  x2_alternates_a: assert property (
    (ratio_code == clock_select_pkg::RATIO_X2) [*4] |-> tick != $past(tick))
    else $error("x2 enable does not alternate");

endmodule : ratio_divider
`default_nettype wire

// ---- rtl/module_stop_ctrl.sv ----
// Sequencer for all-module clock stop entered on a sleep request
`timescale 1ns/1ps
`default_nettype none
module module_stop_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire clock_select_pkg::module_stop_t stop_ctrl,
  input wire logic sleep_request,
  input wire logic bus_io_halted,
  input wire logic wake_request,
  output clock_select_pkg::stop_state_t state,
  output logic all_clock_stopped
);

  logic all_gated;
  clock_select_pkg::stop_state_t next_state;

  // Every gated peripheral must already sit in module stop
  assign all_gated = stop_ctrl.dma_module_stop & stop_ctrl.timer_module_stop;

  // Next state of the stop sequence
  always_comb begin
    next_state = state;
    case (state)
      clock_select_pkg::STOP_IDLE: begin
        if (stop_ctrl.all_clock_stop_enable && all_gated && sleep_request) begin
          next_state = clock_select_pkg::STOP_WAIT_HALT;
        end
      end
      clock_select_pkg::STOP_WAIT_HALT: begin
        if (wake_request || !stop_ctrl.all_clock_stop_enable || !all_gated) begin
          next_state = clock_select_pkg::STOP_IDLE;
        end else if (bus_io_halted) begin
          next_state = clock_select_pkg::STOP_STOPPED;
        end
      end
      clock_select_pkg::STOP_STOPPED: begin
        if (wake_request) begin
          next_state = clock_select_pkg::STOP_IDLE;
        end
      end
      default: begin
        next_state = clock_select_pkg::STOP_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= clock_select_pkg::STOP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Stopped flag, registered with the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_clock_stopped <= 1'b0;
    end else begin
      all_clock_stopped <= (next_state == clock_select_pkg::STOP_STOPPED);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_needs_halt_a: assert property (
    $rose(all_clock_stopped) |-> $past(bus_io_halted) && $past(all_gated) && $past(stop_ctrl.all_clock_stop_enable))
    else $error("clock stop without halt or enable");
  stop_disabled_a: assert property (
    !stop_ctrl.all_clock_stop_enable && !all_clock_stopped |=> !all_clock_stopped)
    else $error("clock stop entered while disabled");

  enter_stop_c: cover property ($rose(all_clock_stopped));
  wake_c: cover property (all_clock_stopped ##1 !all_clock_stopped);

endmodule : module_stop_ctrl
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking testbench for clock ratio selection and module stop
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, sleep_request, bus_io_halted, wake_request;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, r;
  logic [3:0] pstrb;
  logic pready, pslverr, rd_err, system_clk_en, peripheral_clk_en, bus_clk_en;
  logic dma_module_stop, all_clock_stopped;
  logic [5:0] timer_channel_stop;
  logic [2:0] m_sys, m_per, m_bus;
  logic m_all_clock_stop_enable, m_dma, m_tim;
  logic [31:0] seed = 32'h0000f275;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int cs, cp, cb;

  clock_select_and_module_stop dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_request(sleep_request), .bus_io_halted(bus_io_halted),
    .wake_request(wake_request), .system_clk_en(system_clk_en), .peripheral_clk_en(peripheral_clk_en),
    .bus_clk_en(bus_clk_en), .dma_module_stop(dma_module_stop), .timer_channel_stop(timer_channel_stop),
    .all_clock_stopped(all_clock_stopped));

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  // Cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // Xorshift source with a fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Reserved codes leave the field as it was
  function automatic logic [2:0] keep(input logic [2:0] old, input logic [2:0] code, input logic sys);
    if (code == 3'h0 || (!sys && code == 3'h1)) return code;
    return old;
  endfunction : keep

  // Enables seen in eight cycles for a code
  function automatic int rate(input logic [2:0] code);
    return (code == 3'h0) ? 8 : 4;
  endfunction : rate

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [23:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic count_en(output int s, output int p, output int b);
    s = 0;
    p = 0;
    b = 0;
    repeat (8) begin
      @(posedge pclk);
      s += (system_clk_en === 1'b1);
      p += (peripheral_clk_en === 1'b1);
      b += (bus_clk_en === 1'b1);
    end
  endtask : count_en

  // Write a register, follow it in the model, then read and check every effect
  task automatic do_reg(input logic stop, input logic [31:0] d, input logic [3:0] s);
    logic [23:0] a;
    logic [31:0] e;
    a = stop ? clock_select_pkg::MODULE_STOP_CONTROL_A_ADDR : clock_select_pkg::CLOCK_RATIO_CONTROL_ADDR;
    apb(1'b1, a, d, s);
    check("write error", 32'h0, {31'h0, rd_err});
    if (stop) begin
      if (s[1]) {m_all_clock_stop_enable, m_dma} = d[15:14];
      if (s[0]) m_tim = d[0];
      e = {16'h0, m_all_clock_stop_enable, m_dma, 13'h0, m_tim};
    end else begin
      if (s[1]) m_sys = keep(m_sys, d[10:8], 1'b1);
      if (s[0]) begin
        m_per = keep(m_per, d[6:4], 1'b0);
        m_bus = keep(m_bus, d[2:0], 1'b0);
      end
      e = {21'h0, m_sys, 1'b0, m_per, 1'b0, m_bus};
    end
    apb(1'b0, a, 32'h0, 4'hf);
    check("read error", 32'h0, {31'h0, rd_err});
    check("readback", e, rd_data);
    check("dma stop", {31'h0, m_dma}, {31'h0, dma_module_stop});
    check("timer stop", {26'h0, {6{m_tim}}}, {26'h0, timer_channel_stop});
    count_en(cs, cp, cb);
    check("system rate", rate(m_sys), cs);
    check("peripheral rate", rate(m_per), cp);
    check("bus rate", rate(m_bus), cb);
  endtask : do_reg

  task automatic wait_flag(input logic want);
    int n;
    n = 0;
    while (all_clock_stopped !== want && n < 8) begin
      @(posedge pclk);
      n++;
    end
    check("all clock stopped", {31'h0, want}, {31'h0, all_clock_stopped});
  endtask : wait_flag

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, sleep_request, bus_io_halted, wake_request} = 8'h0;
    paddr = 24'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    {m_sys, m_per, m_bus} = 9'h008;
    {m_all_clock_stop_enable, m_dma, m_tim} = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    do_reg(1'b0, 32'h0, 4'h0);
    do_reg(1'b1, 32'h0, 4'h0);
    $display("test reset done");
    apb(1'b1, 24'hfffdd0, 32'hffffffff, 4'hf);
    check("unmapped write error", 32'h1, {31'h0, rd_err});
    apb(1'b0, 24'hfffdd0, 32'h0, 4'hf);
    check("unmapped read data", 32'h0, rd_data);
    do_reg(1'b0, 32'h0, 4'h0);
    $display("test unmapped done");
    for (int c = 0; c < 8; c++) do_reg(1'b0, {21'h0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]}, 4'hf);
    $display("test codes done");
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      do_reg(r[31], r[4] ? rnd() & 32'hfffff111 : rnd(), r[3:0]);
    end
    $display("test random done");
    do_reg(1'b1, 32'h00004001, 4'hf);
    sleep_request <= 1'b1;
    bus_io_halted <= 1'b1;
    repeat (8) @(posedge pclk);
    check("stop without enable", 32'h0, {31'h0, all_clock_stopped});
    sleep_request <= 1'b0;
    bus_io_halted <= 1'b0;
    do_reg(1'b1, 32'h0000c001, 4'hf);
    sleep_request <= 1'b1;
    repeat (6) @(posedge pclk);
    check("stop before halt", 32'h0, {31'h0, all_clock_stopped});
    apb(1'b0, clock_select_pkg::CLOCK_STATUS_ADDR, 32'h0, 4'hf);
    check("status waiting", 32'h1 << clock_select_pkg::STATUS_WAIT_HALT_BIT, rd_data);
    bus_io_halted <= 1'b1;
    wait_flag(1'b1);
    apb(1'b0, clock_select_pkg::CLOCK_STATUS_ADDR, 32'h0, 4'hf);
    check("status stopped", 32'h1 << clock_select_pkg::STATUS_STOPPED_BIT, rd_data);
    count_en(cs, cp, cb);
    check("enables while stopped", 32'h0, cs + cp + cb);
    wake_request <= 1'b1;
    sleep_request <= 1'b0;
    @(posedge pclk);
    wake_request <= 1'b0;
    bus_io_halted <= 1'b0;
    wait_flag(1'b0);
    do_reg(1'b1, 32'h0, 4'hf);
    $display("test stop sequence done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
